// File: verilog/aisc_defs.svh
// Purpose: Offsets, field positions, reset values and codes of the light interrupt config block
// Assumes: Included by the design files by its bare name
// Notes: Printed offsets are register indices; byte address is four times the index
`ifndef AISC_DEFS_SVH
`define AISC_DEFS_SVH

// Register indices and own byte addresses
`define AISC_IDX_LIGHT_MODE 8'hA3
`define AISC_IDX_PIN_ROUTE 8'hA4
`define AISC_IDX_SEQ_FMT 8'hA5
`define AISC_ADDR_CTRL 12'h300
`define AISC_ADDR_LOW_THR 12'h304
`define AISC_ADDR_HIGH_THR 12'h308
`define AISC_ADDR_CHAN_SEL 12'h30C
`define AISC_ADDR_IRQ_STAT 12'h310
`define AISC_ADDR_IRQ_MASK 12'h314
`define AISC_ADDR_TRIM 12'h318
`define AISC_ADDR_STATE 12'h31C
`define AISC_ADDR_MSB 11
`define AISC_TRANS_ACTIVE_BIT 1

// light_interrupt_mode_config
`define AISC_MODE_DIRECT_BIT 7
`define AISC_MODE_THR_LSB_BIT 0
`define AISC_MODE_WMASK 8'h81
`define AISC_MODE_RESET 8'h01

// pin_routing_config
`define AISC_IRQ_ROUTE_MSB 5
`define AISC_IRQ_ROUTE_LSB 4
`define AISC_SYNC_ROUTE_MSB 1
`define AISC_SYNC_ROUTE_LSB 0
`define AISC_ROUTE_WMASK 8'h33
`define AISC_ROUTE_RESET 8'h00
`define AISC_ROUTE_GENERAL 2'h0
`define AISC_ROUTE_HYST 2'h1

// sequencer_format_config
`define AISC_SEQ_CAL_STEP_BIT 6
`define AISC_SEQ_AGC_TARGET_BIT 5
`define AISC_SEQ_PER_STEP_BIT 4
`define AISC_SEQ_TRIM_KEEP_BIT 3
`define AISC_SEQ_FMT_MSB 1
`define AISC_SEQ_FMT_LSB 0
`define AISC_SEQ_WMASK 8'h7B
`define AISC_SEQ_RESET 8'h00
`define AISC_FMT_16 2'h0
`define AISC_FMT_24 2'h1
`define AISC_FMT_32 2'h3

// Own control, threshold, channel, interrupt and trim registers
`define AISC_CTRL_POWER_ON_BIT 0
`define AISC_CTRL_SEQ_IRQ_EN_BIT 1
`define AISC_CTRL_WMASK 8'h03
`define AISC_CTRL_RESET 8'h00
`define AISC_CHAN_WMASK 8'h03
`define AISC_CHAN_RESET 8'h00
`define AISC_CHAN_MOD1 2'h1
`define AISC_CHAN_MOD2 2'h2
`define AISC_THR_LOW_RESET 32'h00000000
`define AISC_THR_HIGH_RESET 32'hFFFFFFFF
`define AISC_IRQ_LIGHT_BIT 0
`define AISC_IRQ_SEQ_BIT 1
`define AISC_IRQ_WMASK 8'h03
`define AISC_TRIM_RESET 8'h00

// Queue word codes
`define AISC_FULL_16 32'h0000FFFF
`define AISC_FULL_24 32'h00FFFFFF
`define AISC_FULL_32 32'hFFFFFFFF
`define AISC_DSAT_STEP 32'h00000001
`define AISC_CLAMP_STEP 32'h00000002
`define AISC_AGC_HALF_SHIFT 1
`define AISC_AGC_QUARTER_SHIFT 2

`endif

// File: verilog/aisc_pkg.sv
// Purpose: Shared types of the light interrupt config block
// Assumes: Constants live in aisc_defs.svh
// Notes: Types only
package aisc_pkg;
  typedef logic [7:0] aisc_reg8_t;
  typedef logic [31:0] aisc_word_t;
  typedef logic [1:0] aisc_fmt_t;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} aisc_phase_e;
endpackage

// File: verilog/aisc_word_fmt.sv
// Purpose: Shapes light data into queue words of the selected width
// Assumes: Saturation flags qualify the raw value of the same cycle
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/100ps
`include "aisc_defs.svh"

module aisc_word_fmt (
  input wire aisc_pkg::aisc_fmt_t fmt_i,
  input wire aisc_pkg::aisc_word_t raw_i,
  input wire logic analog_sat_i,
  input wire logic digital_sat_i,
  output aisc_pkg::aisc_word_t full_scale_o,
  output aisc_pkg::aisc_word_t word_o
);
  import aisc_pkg::*;

  aisc_word_t full;
  aisc_word_t ceiling;
  aisc_word_t clipped;

  // Reserved format falls back to 16-bit words
  assign full = (fmt_i == `AISC_FMT_24) ? `AISC_FULL_24 :
                (fmt_i == `AISC_FMT_32) ? `AISC_FULL_32 : `AISC_FULL_16; // [R12]
  // Measured data is kept below the two flag codes so it cannot fake them
  assign ceiling = full - `AISC_CLAMP_STEP;
  assign clipped = (raw_i > ceiling) ? ceiling : raw_i;
  assign full_scale_o = full;
  assign word_o = analog_sat_i ? full :
                  digital_sat_i ? (full - `AISC_DSAT_STEP) : clipped; // [R13] [R14]
endmodule

// File: verilog/aisc_top.sv
// Purpose: Light interrupt, pin route and sequencer config over AHB-Lite
// Assumes: Single 125 MHz clock; inputs synchronous to clk_i; word-only single transfers
// Notes: Zero wait states; haddr bits above 11 are not decoded
// Function
// (R1) Direct mode: interrupt only on hysteresis edge crossings.
// (R2) Normal mode: interrupt while data lies outside thresholds.
// (R3) Direct status reaches a pin only if routed there.
// (R4) Mode bit 0: queue threshold LSB, read/write, reset one.
// (R5) Interrupt pin route 5:4: 00 interrupt, 01 hysteresis.
// (R6) Sync pin route 1:0: 00 normal, 01 hysteresis.
// (R7) Bit 6: nth-iteration calibration per step.
// (R8) Host keeps bit 6 clear under gain control.
// (R9) Bit 5: gain target half or quarter of maximum.
// (R10) Bit 4: sequencer interrupt per step, else per round.
// (R11) Power-on rise clears trim unless bit 3 set.
// (R12) Format: 00 16-bit, 01 24-bit, 11 32-bit.
// (R13) 16-bit flags: analog 0xFFFF, digital 0xFFFE.
// (R14) 24-bit flags: analog 0xFFFFFF, digital just below.
// (R15) Channel: 00/11 modulator 0, 01 one, 10 two.
// (R16) Sequencer flag set when enabled; write one clears.
// (R17) Hysteresis rises above high, falls below low.
// (R18) Reserved bits read zero, ignore writes.
`timescale 1ns/100ps
`include "aisc_defs.svh"

module aisc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire aisc_pkg::aisc_word_t haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire aisc_pkg::aisc_word_t hwdata_i,
  input wire logic hready_i,
  output aisc_pkg::aisc_word_t hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire aisc_pkg::aisc_word_t light_mod0_i,
  input wire aisc_pkg::aisc_word_t light_mod1_i,
  input wire aisc_pkg::aisc_word_t light_mod2_i,
  input wire logic light_sample_valid_i,
  input wire logic seq_step_done_i,
  input wire logic seq_round_done_i,
  input wire logic calib_nth_iter_i,
  input wire logic sync_pin_normal_i,
  input wire aisc_pkg::aisc_word_t queue_raw_i,
  input wire logic queue_raw_valid_i,
  input wire logic analog_sat_i,
  input wire logic digital_sat_i,
  output logic irq_o,
  output logic irq_pin_o,
  output logic sync_pin_o,
  output logic hysteresis_state_o,
  output aisc_pkg::aisc_word_t queue_word_o,
  output logic queue_word_valid_o,
  output logic queue_threshold_lsb_o,
  output logic calib_start_o,
  output logic calib_per_step_o,
  output aisc_pkg::aisc_word_t agc_target_level_o,
  output aisc_pkg::aisc_reg8_t oscillator_trim_o
);
  import aisc_pkg::*;

  function automatic logic [`AISC_ADDR_MSB:0] idx2addr(input logic [7:0] idx);
    idx2addr = {2'h0, idx, 2'h0};
  endfunction

  // Masked register update; reserved bits stay zero
  function automatic aisc_reg8_t upd8(input logic we, input aisc_reg8_t cur, input aisc_reg8_t wd,
                                      input aisc_reg8_t wmask);
    upd8 = we ? (wd & wmask) : cur;
  endfunction

  function automatic aisc_word_t chan_pick(input logic [1:0] sel, input aisc_word_t m0,
                                           input aisc_word_t m1, input aisc_word_t m2);
    chan_pick = (sel == `AISC_CHAN_MOD1) ? m1 : (sel == `AISC_CHAN_MOD2) ? m2 : m0;
  endfunction

  // Pin route decode shared by both pins
  function automatic logic route_pick(input logic [1:0] route, input logic normal, input logic hyst);
    route_pick = (route == `AISC_ROUTE_GENERAL) ? normal : (route == `AISC_ROUTE_HYST) ? hyst : 1'b0;
  endfunction

  aisc_reg8_t light_interrupt_mode_config;
  aisc_reg8_t pin_routing_config;
  aisc_reg8_t sequencer_format_config;
  aisc_reg8_t ctrl;
  aisc_reg8_t chan_sel;
  aisc_reg8_t irq_status;
  aisc_reg8_t irq_mask;
  aisc_reg8_t oscillator_trim;
  aisc_word_t low_threshold;
  aisc_word_t high_threshold;
  logic hysteresis_state;
  logic power_on_q;
  aisc_phase_e phase;
  logic [`AISC_ADDR_MSB:0] wr_addr;

  // Bus address phase
  wire addr_take = hsel_i & hready_i & htrans_i[`AISC_TRANS_ACTIVE_BIT];
  wire [`AISC_ADDR_MSB:0] rd_addr = haddr_i[`AISC_ADDR_MSB:0];
  wire wr_live = (phase == PH_WRITE);
  wire aisc_reg8_t wbyte = hwdata_i[7:0];

  // Write decode in the data phase
  wire we_mode = wr_live & (wr_addr == idx2addr(`AISC_IDX_LIGHT_MODE));
  wire we_route = wr_live & (wr_addr == idx2addr(`AISC_IDX_PIN_ROUTE));
  wire we_seq = wr_live & (wr_addr == idx2addr(`AISC_IDX_SEQ_FMT));
  wire we_ctrl = wr_live & (wr_addr == `AISC_ADDR_CTRL);
  wire we_low = wr_live & (wr_addr == `AISC_ADDR_LOW_THR);
  wire we_high = wr_live & (wr_addr == `AISC_ADDR_HIGH_THR);
  wire we_chan = wr_live & (wr_addr == `AISC_ADDR_CHAN_SEL);
  wire we_stat = wr_live & (wr_addr == `AISC_ADDR_IRQ_STAT);
  wire we_mask = wr_live & (wr_addr == `AISC_ADDR_IRQ_MASK);
  wire we_trim = wr_live & (wr_addr == `AISC_ADDR_TRIM);

  // Field views
  wire direct_mode = light_interrupt_mode_config[`AISC_MODE_DIRECT_BIT];
  wire [1:0] irq_pin_route = pin_routing_config[`AISC_IRQ_ROUTE_MSB:`AISC_IRQ_ROUTE_LSB];
  wire [1:0] sync_pin_route = pin_routing_config[`AISC_SYNC_ROUTE_MSB:`AISC_SYNC_ROUTE_LSB];
  wire cal_per_step = sequencer_format_config[`AISC_SEQ_CAL_STEP_BIT];
  wire agc_quarter = sequencer_format_config[`AISC_SEQ_AGC_TARGET_BIT];
  wire sint_per_step = sequencer_format_config[`AISC_SEQ_PER_STEP_BIT];
  wire trim_keep_on_powerup = sequencer_format_config[`AISC_SEQ_TRIM_KEEP_BIT];
  wire aisc_fmt_t queue_word_format = sequencer_format_config[`AISC_SEQ_FMT_MSB:`AISC_SEQ_FMT_LSB];
  wire power_on_bit = ctrl[`AISC_CTRL_POWER_ON_BIT];
  wire seq_irq_enable = ctrl[`AISC_CTRL_SEQ_IRQ_EN_BIT];

  // Threshold compare on the selected channel
  wire aisc_word_t light_sample_value = chan_pick(chan_sel[1:0], light_mod0_i, light_mod1_i,
                                                  light_mod2_i); // [R15]
  wire above_high = light_sample_value > high_threshold;
  wire below_low = light_sample_value < low_threshold;
  wire hyst_high_edge = ~hysteresis_state & above_high;
  wire hyst_low_edge = hysteresis_state & below_low;
  wire next_hysteresis_state = !light_sample_valid_i ? hysteresis_state :
                               above_high ? 1'b1 :
                               below_low ? 1'b0 : hysteresis_state; // [R17]
  // Edge in direct mode, level otherwise
  wire light_event = light_sample_valid_i &
                     (direct_mode ? (hyst_high_edge | hyst_low_edge) // [R1]
                                  : (above_high | below_low)); // [R2]

  // Sequencer events
  wire seq_done = sint_per_step ? seq_step_done_i : seq_round_done_i; // [R10]
  wire seq_event = seq_irq_enable & seq_done; // [R16]
  wire cal_done = cal_per_step ? seq_step_done_i : seq_round_done_i; // [R7]
  // Host must keep cal_per_step clear under gain control; not enforced here [R8]
  wire next_calib_start = calib_nth_iter_i & cal_done; // [R7]

  // Sticky status, set wins over a write-one clear
  wire aisc_reg8_t stat_set = {6'h00, seq_event, light_event};
  wire aisc_reg8_t stat_clr = we_stat ? (wbyte & `AISC_IRQ_WMASK) : 8'h00;
  wire aisc_reg8_t next_irq_status = (irq_status & ~stat_clr) | stat_set; // [R16]
  wire irq_any = |(irq_status & irq_mask);

  // Pin routing
  wire next_irq_pin = route_pick(irq_pin_route, irq_any, hysteresis_state); // [R3] [R5]
  wire next_sync_pin = route_pick(sync_pin_route, sync_pin_normal_i, hysteresis_state); // [R3] [R6]

  // Trim retention across power-on
  wire power_on_rise = power_on_bit & ~power_on_q;
  wire aisc_reg8_t next_oscillator_trim = we_trim ? wbyte :
                                          (power_on_rise & ~trim_keep_on_powerup) ? `AISC_TRIM_RESET :
                                          oscillator_trim; // [R11]

  // Queue word shaping
  aisc_word_t fmt_word;
  aisc_word_t fmt_full;

  aisc_word_fmt u_word_fmt (
    .fmt_i(queue_word_format),
    .raw_i(queue_raw_i),
    .analog_sat_i(analog_sat_i),
    .digital_sat_i(digital_sat_i),
    .full_scale_o(fmt_full),
    .word_o(fmt_word)
  ); // [R12] [R13] [R14]

  wire aisc_word_t next_agc_target = agc_quarter ? (fmt_full >> `AISC_AGC_QUARTER_SHIFT)
                                                 : (fmt_full >> `AISC_AGC_HALF_SHIFT); // [R9]

  // Read mux, sampled in the address phase
  wire aisc_word_t rd_word =
    (rd_addr == idx2addr(`AISC_IDX_LIGHT_MODE)) ? {24'h000000, light_interrupt_mode_config} :
    (rd_addr == idx2addr(`AISC_IDX_PIN_ROUTE)) ? {24'h000000, pin_routing_config} :
    (rd_addr == idx2addr(`AISC_IDX_SEQ_FMT)) ? {24'h000000, sequencer_format_config} :
    (rd_addr == `AISC_ADDR_CTRL) ? {24'h000000, ctrl} :
    (rd_addr == `AISC_ADDR_LOW_THR) ? low_threshold :
    (rd_addr == `AISC_ADDR_HIGH_THR) ? high_threshold :
    (rd_addr == `AISC_ADDR_CHAN_SEL) ? {24'h000000, chan_sel} :
    (rd_addr == `AISC_ADDR_IRQ_STAT) ? {24'h000000, irq_status} :
    (rd_addr == `AISC_ADDR_IRQ_MASK) ? {24'h000000, irq_mask} :
    (rd_addr == `AISC_ADDR_TRIM) ? {24'h000000, oscillator_trim} :
    (rd_addr == `AISC_ADDR_STATE) ? {28'h0000000, sync_pin_o, irq_pin_o, irq_o, hysteresis_state} :
    32'h00000000; // [R18]

  wire aisc_phase_e next_phase = !addr_take ? PH_IDLE : hwrite_i ? PH_WRITE : PH_READ;

  // Bus slave; hsize is not checked since only word transfers arrive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PH_IDLE;
      wr_addr <= 12'h000;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      phase <= next_phase;
      wr_addr <= addr_take ? rd_addr : wr_addr;
      hrdata_o <= (addr_take & ~hwrite_i) ? rd_word : hrdata_o;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      light_interrupt_mode_config <= `AISC_MODE_RESET; // [R4]
      pin_routing_config <= `AISC_ROUTE_RESET;
      sequencer_format_config <= `AISC_SEQ_RESET;
      ctrl <= `AISC_CTRL_RESET;
      chan_sel <= `AISC_CHAN_RESET;
      irq_mask <= 8'h00;
    end else begin
      light_interrupt_mode_config <= upd8(we_mode, light_interrupt_mode_config, wbyte,
                                          `AISC_MODE_WMASK); // [R18]
      pin_routing_config <= upd8(we_route, pin_routing_config, wbyte, `AISC_ROUTE_WMASK); // [R18]
      sequencer_format_config <= upd8(we_seq, sequencer_format_config, wbyte, `AISC_SEQ_WMASK); // [R18]
      ctrl <= upd8(we_ctrl, ctrl, wbyte, `AISC_CTRL_WMASK);
      chan_sel <= upd8(we_chan, chan_sel, wbyte, `AISC_CHAN_WMASK);
      irq_mask <= upd8(we_mask, irq_mask, wbyte, `AISC_IRQ_WMASK);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_threshold <= `AISC_THR_LOW_RESET;
      high_threshold <= `AISC_THR_HIGH_RESET;
    end else begin
      low_threshold <= we_low ? hwdata_i : low_threshold;
      high_threshold <= we_high ? hwdata_i : high_threshold;
    end
  end

  // Event state and trim
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= 8'h00;
      hysteresis_state <= 1'b0;
      power_on_q <= 1'b0;
      oscillator_trim <= `AISC_TRIM_RESET;
    end else begin
      irq_status <= next_irq_status;
      hysteresis_state <= next_hysteresis_state;
      power_on_q <= power_on_bit;
      oscillator_trim <= next_oscillator_trim;
    end
  end

  // Registered outputs; pins trail their sources by one cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      irq_pin_o <= 1'b0;
      sync_pin_o <= 1'b0;
      hysteresis_state_o <= 1'b0;
      calib_start_o <= 1'b0;
      calib_per_step_o <= 1'b0;
      queue_threshold_lsb_o <= 1'b1;
      agc_target_level_o <= 32'h00000000;
      oscillator_trim_o <= `AISC_TRIM_RESET;
    end else begin
      irq_o <= irq_any;
      irq_pin_o <= next_irq_pin;
      sync_pin_o <= next_sync_pin;
      hysteresis_state_o <= hysteresis_state;
      calib_start_o <= next_calib_start;
      calib_per_step_o <= cal_per_step;
      queue_threshold_lsb_o <= light_interrupt_mode_config[`AISC_MODE_THR_LSB_BIT]; // [R4]
      agc_target_level_o <= next_agc_target;
      oscillator_trim_o <= oscillator_trim;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      queue_word_o <= 32'h00000000;
      queue_word_valid_o <= 1'b0;
    end else begin
      queue_word_o <= queue_raw_valid_i ? fmt_word : queue_word_o;
      queue_word_valid_o <= queue_raw_valid_i;
    end
  end
endmodule

// File: dv/aisc_props.sv
// Purpose: Port-level assertions for the light interrupt config block
// Assumes: Shadow copies follow bus writes
// Notes: Gate skips the first edges after reset
`timescale 1ns/100ps
`include "aisc_defs.svh"

module aisc_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire aisc_pkg::aisc_word_t haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire aisc_pkg::aisc_word_t hwdata_i,
  input wire logic hready_i,
  input wire logic seq_step_done_i,
  input wire logic seq_round_done_i,
  input wire logic calib_nth_iter_i,
  input wire logic sync_pin_normal_i,
  input wire logic queue_raw_valid_i,
  input wire logic analog_sat_i,
  input wire logic digital_sat_i,
  input wire logic irq_o,
  input wire logic irq_pin_o,
  input wire logic sync_pin_o,
  input wire logic hysteresis_state_o,
  input wire aisc_pkg::aisc_word_t queue_word_o,
  input wire logic queue_word_valid_o,
  input wire logic queue_threshold_lsb_o,
  input wire logic calib_start_o,
  input wire aisc_pkg::aisc_word_t agc_target_level_o
);
  import aisc_pkg::*;
  aisc_reg8_t md, rt, sq;
  logic [11:0] wa;
  logic wp;
  logic [1:0] age;
  wire ok = (age == 2'h3);
  wire take_w = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  wire aisc_word_t full = (sq[1:0] == `AISC_FMT_24) ? `AISC_FULL_24 :
    (sq[1:0] == `AISC_FMT_32) ? `AISC_FULL_32 : `AISC_FULL_16;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      md <= `AISC_MODE_RESET;
      rt <= `AISC_ROUTE_RESET;
      sq <= `AISC_SEQ_RESET;
      wp <= 1'b0;
      wa <= 12'h000;
      age <= 2'h0;
    end else begin
      wp <= take_w;
      wa <= haddr_i[11:0];
      age <= ok ? age : age + 2'h1;
      if (wp && wa == 12'h28C) md <= hwdata_i[7:0] & `AISC_MODE_WMASK;
      if (wp && wa == 12'h290) rt <= hwdata_i[7:0] & `AISC_ROUTE_WMASK;
      if (wp && wa == 12'h294) sq <= hwdata_i[7:0] & `AISC_SEQ_WMASK;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  lsb_track_a: assert property (ok && $stable(md) |-> queue_threshold_lsb_o == md[0])
    else $error("lsb mismatch");
  irq_route_a: assert property (ok && $stable(rt) |->
    irq_pin_o == (rt[5:4] == 2'h0 ? irq_o : (rt[5:4] == 2'h1 && hysteresis_state_o)))
    else $error("irq pin route");
  sync_route_a: assert property (ok && $stable(rt) |->
    sync_pin_o == (rt[1:0] == 2'h0 ? $past(sync_pin_normal_i) : (rt[1:0] == 2'h1 && hysteresis_state_o)))
    else $error("sync pin route wrong");
  agc_level_a: assert property (ok && $stable(sq) |->
    agc_target_level_o == (sq[5] ? full >> 2 : full >> 1))
    else $error("gain target level wrong");
  calib_start_a: assert property (ok |->
    calib_start_o == $past(calib_nth_iter_i && (sq[6] ? seq_step_done_i : seq_round_done_i)))
    else $error("calib start");
  analog16_a: assert property (queue_raw_valid_i && analog_sat_i && sq[1:0] == `AISC_FMT_16
    |=> queue_word_valid_o && queue_word_o == `AISC_FULL_16)
    else $error("16-bit analog flag wrong");
  digital16_a: assert property (queue_raw_valid_i && digital_sat_i && !analog_sat_i && sq[1:0] == 2'h0
    |=> queue_word_valid_o && queue_word_o == 32'h0000FFFE)
    else $error("16-bit digital flag wrong");
  analog24_a: assert property (queue_raw_valid_i && analog_sat_i && sq[1:0] == `AISC_FMT_24
    |=> queue_word_valid_o && queue_word_o == `AISC_FULL_24)
    else $error("24-bit analog flag wrong");

  cover property (queue_word_valid_o && queue_word_o == full);
  cover property ($rose(irq_o));
  cover property (calib_start_o && sq[6]);
endmodule

bind aisc_top aisc_props u_props (.*);

// File: dv/aisc_host_model.sv
// Purpose: Host processor model, an AHB-Lite master of single word transfers
// Assumes: One slave, whose hreadyout is the bus hready
// Notes: Waits are bounded; a stuck bus ends the run through the bench
`timescale 1ns/100ps

module aisc_host_model (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire aisc_pkg::aisc_word_t hrdata_i,
  output logic hsel_o,
  output aisc_pkg::aisc_word_t haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output aisc_pkg::aisc_word_t hwdata_o
);
  import aisc_pkg::*;
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!hready_i && n < 64);
    if (hready_i !== 1'b1) begin
      aisc_top_tb.n_fail++;
      aisc_top_tb.complete_run();
    end
  endtask

  // Callers do not keep bit 6 clear; t_regs and t_seq set it at 0x294
  task automatic xfer(input logic wr, input logic [11:0] a, input aisc_word_t wd, output aisc_word_t rd);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {20'h0, a};
    hwrite_o <= wr;
    htrans_o <= 2'h2;
    wait_ready();
    htrans_o <= 2'h0;
    hsel_o <= 1'b0;
    hwdata_o <= wd;
    wait_ready();
    rd = hrdata_i;
  endtask
endmodule

// File: dv/aisc_top_tb.sv
// Purpose: Self-checking bench of the light interrupt config block
// Assumes: Host model drives the register bus; bench drives sensor side
// Notes: Expected values come from field layouts, not from the design
`timescale 1ns/100ps
`include "aisc_defs.svh"

module aisc_top_tb;
  import aisc_pkg::*;
  logic clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, lvalid, step, round, nth, sync_n, qvalid, asat, dsat;
  logic irq_o, irq_pin_o, sync_pin_o, hyst, qv_o, cps;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  aisc_word_t haddr_i, hwdata_i, hrdata_o, m0, m1, m2, raw, qword_o, agc_o, rd;
  aisc_reg8_t trim_o;
  int n_fail, n_tests;
  logic [7:0] cfg[4] = '{8'h00, 8'h21, 8'h03, 8'h20};

  aisc_host_model host (.clk_i(clk_i), .hready_i(hreadyout_o), .hrdata_i(hrdata_o), .hsel_o(hsel_i),
    .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i), .hwdata_o(hwdata_i));
  aisc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(), .light_mod0_i(m0), .light_mod1_i(m1), .light_mod2_i(m2),
    .light_sample_valid_i(lvalid), .seq_step_done_i(step), .seq_round_done_i(round), .calib_nth_iter_i(nth),
    .sync_pin_normal_i(sync_n), .queue_raw_i(raw), .queue_raw_valid_i(qvalid), .analog_sat_i(asat),
    .digital_sat_i(dsat), .irq_o(irq_o), .irq_pin_o(irq_pin_o), .sync_pin_o(sync_pin_o),
    .hysteresis_state_o(hyst), .queue_word_o(qword_o), .queue_word_valid_o(qv_o), .queue_threshold_lsb_o(),
    .calib_start_o(), .calib_per_step_o(cps), .agc_target_level_o(agc_o), .oscillator_trim_o(trim_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input aisc_word_t exp, input aisc_word_t got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input aisc_word_t d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input aisc_word_t exp);
    host.xfer(1'b0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask
  task automatic sample(input aisc_word_t a, input aisc_word_t b, input aisc_word_t c);
    @(posedge clk_i);
    m0 <= a;
    m1 <= b;
    m2 <= c;
    lvalid <= 1'b1;
    @(posedge clk_i);
    lvalid <= 1'b0;
    tick(3);
  endtask
  task automatic pulse(input logic s, input logic r, input logic n);
    @(posedge clk_i);
    step <= s;
    round <= r;
    nth <= n;
    @(posedge clk_i);
    step <= 1'b0;
    round <= 1'b0;
    nth <= 1'b0;
    tick(3);
  endtask
  task automatic qpush(input aisc_word_t w, input logic a, input logic d, input aisc_word_t exp);
    @(posedge clk_i);
    raw <= w;
    asat <= a;
    dsat <= d;
    qvalid <= 1'b1;
    @(posedge clk_i);
    qvalid <= 1'b0;
    @(negedge clk_i);
    chk("queue valid", 32'h1, {31'h0, qv_o});
    chk("queue word", exp, qword_o);
  endtask

  task automatic t_regs();
    rdchk("mode reset", 12'h28C, 32'h01);
    rdchk("route reset", 12'h290, 32'h00);
    rdchk("seq reset", 12'h294, 32'h00);
    wr(12'h28C, 32'hFFFFFFFF);
    wr(12'h290, 32'hFFFFFFFF);
    wr(12'h294, 32'hFFFFFFFF);
    rdchk("mode bits", 12'h28C, 32'h81);
    rdchk("route bits", 12'h290, 32'h33);
    rdchk("seq bits", 12'h294, 32'h7B);
    wr(12'h28C, 32'h0);
    rdchk("lsb cleared", 12'h28C, 32'h0);
    rdchk("unmapped", 12'h3F0, 32'h0);
    wr(12'h290, 32'h0);
  endtask

  task automatic t_queue();
    aisc_word_t full;
    for (int i = 0; i < 4; i++) begin
      wr(12'h294, {24'h0, cfg[i]});
      full = cfg[i][1:0] == 2'h1 ? 32'h00FFFFFF : cfg[i][1:0] == 2'h3 ? 32'hFFFFFFFF : 32'h0000FFFF;
      tick(3);
      chk("gain target", cfg[i][5] ? full >> 2 : full >> 1, agc_o);
      qpush(32'h5, 1'b1, 1'b0, full);
      qpush(32'h5, 1'b0, 1'b1, full - 32'h1);
      qpush(32'h1234, 1'b0, 1'b0, 32'h1234);
    end
  endtask

  task automatic t_light();
    wr(12'h304, 32'd100);
    wr(12'h308, 32'd200);
    wr(12'h314, 32'h1);
    sample(32'd300, 32'd0, 32'd0);
    chk("hyst rise", 32'h1, {31'h0, hyst});
    chk("irq above", 32'h1, {31'h0, irq_o});
    wr(12'h310, 32'h1);
    tick(2);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    sample(32'd150, 32'd0, 32'd0);
    chk("hyst hold", 32'h1, {31'h0, hyst});
    chk("irq inside", 32'h0, {31'h0, irq_o});
    sample(32'd300, 32'd0, 32'd0);
    chk("irq again", 32'h1, {31'h0, irq_o});
    wr(12'h310, 32'h1);
    wr(12'h28C, 32'h80);
    sample(32'd300, 32'd0, 32'd0);
    chk("direct no edge", 32'h0, {31'h0, irq_o});
    sample(32'd50, 32'd0, 32'd0);
    chk("direct low edge", 32'h1, {31'h0, irq_o});
    chk("hyst fall", 32'h0, {31'h0, hyst});
    wr(12'h310, 32'h1);
    wr(12'h290, 32'h11);
    sample(32'd300, 32'd0, 32'd0);
    chk("irq pin hyst", 32'h1, {31'h0, irq_pin_o});
    chk("sync pin hyst", 32'h1, {31'h0, sync_pin_o});
    for (int c = 0; c < 4; c++) begin
      wr(12'h30C, c);
      sample(c % 3 == 0 ? 32'd50 : 32'd300, c == 1 ? 32'd50 : 32'd300, c == 2 ? 32'd50 : 32'd300);
      chk("channel low", 32'h0, {31'h0, hyst});
      sample(c % 3 == 0 ? 32'd300 : 32'd50, c == 1 ? 32'd300 : 32'd50, c == 2 ? 32'd300 : 32'd50);
      chk("channel high", 32'h1, {31'h0, hyst});
    end
    wr(12'h290, 32'h0);
    sync_n <= 1'b1;
    tick(3);
    chk("sync normal", 32'h1, {31'h0, sync_pin_o});
  endtask

  task automatic t_seq();
    wr(12'h310, 32'h3);
    wr(12'h300, 32'h2);
    wr(12'h314, 32'h2);
    wr(12'h294, 32'h0);
    pulse(1'b1, 1'b0, 1'b1);
    chk("step ignored", 32'h0, {31'h0, irq_o});
    pulse(1'b0, 1'b1, 1'b1);
    chk("round irq", 32'h1, {31'h0, irq_o});
    wr(12'h310, 32'h2);
    tick(2);
    chk("seq cleared", 32'h0, {31'h0, irq_o});
    wr(12'h294, 32'h50);
    pulse(1'b1, 1'b0, 1'b1);
    chk("cal per step", 32'h1, {31'h0, cps});
    chk("step irq", 32'h1, {31'h0, irq_o});
    wr(12'h310, 32'h2);
  endtask

  task automatic t_trim();
    wr(12'h294, 32'h0);
    wr(12'h318, 32'h5A);
    wr(12'h300, 32'h1);
    tick(3);
    chk("trim port", 32'h0, {24'h0, trim_o});
    rdchk("trim cleared", 12'h318, 32'h0);
    wr(12'h300, 32'h0);
    wr(12'h294, 32'h08);
    wr(12'h318, 32'h5A);
    wr(12'h300, 32'h1);
    tick(2);
    rdchk("trim kept", 12'h318, 32'h5A);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    n_tests = 0;
    rst_i = 1'b1;
    {lvalid, step, round, nth, sync_n, qvalid, asat, dsat} = 8'h00;
    {m0, m1, m2, raw} = '0;
    tick(2);
    rst_i <= 1'b0;
    t_regs();
    t_queue();
    t_light();
    t_seq();
    t_trim();
    complete_run();
  end
endmodule
